// ### pkg/can_filter_pkg.sv
/*
 * Register map, field positions and reset values for the CAN event flag
 * and acceptance filter block.
 * Assumes word-aligned APB access: byte address = 4 * register index.
 */
package can_filter_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL     = 6'h00;
	localparam logic [5:0] IDX_COMMAND     = 6'h01;
	localparam logic [5:0] IDX_STATUS      = 6'h02;
	localparam logic [5:0] IDX_EVENT_FLAGS = 6'h03;
	localparam logic [5:0] IDX_FILTER_CODE = 6'h04;
	localparam logic [5:0] IDX_FILTER_MASK = 6'h05;
	localparam logic [5:0] IDX_RX_WINDOW   = 6'h14;

	// control_reg fields
	localparam int CTL_TEST_MODE = 7;
	localparam int CTL_REF_OE    = 5;
	localparam int CTL_OVR_IE    = 4;
	localparam int CTL_ERR_IE    = 3;
	localparam int CTL_TX_IE     = 2;
	localparam int CTL_RX_IE     = 1;
	localparam int CTL_RESET_REQ = 0;

	// command_reg fields
	localparam int CMD_IN0_SEL = 7;
	localparam int CMD_IN1_SEL = 6;
	localparam int CMD_SLEEP   = 4;
	localparam int CMD_CLR_OVR = 3;
	localparam int CMD_RELEASE = 2;
	localparam int CMD_ABORT   = 1;
	localparam int CMD_TX_REQ  = 0;

	// status_reg fields
	localparam int ST_BUS_OFF  = 7;
	localparam int ST_WARNING  = 6;
	localparam int ST_TX_BUSY  = 5;
	localparam int ST_RX_BUSY  = 4;
	localparam int ST_TX_DONE  = 3;
	localparam int ST_TX_FREE  = 2;
	localparam int ST_OVERRUN  = 1;
	localparam int ST_RX_FULL  = 0;

	// event_flags fields
	localparam int FLAG_W      = 5;
	localparam int FLG_WAKE    = 4;
	localparam int FLG_OVERRUN = 3;
	localparam int FLG_ERROR   = 2;
	localparam int FLG_TX      = 1;
	localparam int FLG_RX      = 0;

	// Reset values
	localparam logic [7:0] FILTER_CODE_RST = 8'h00;
	localparam logic [7:0] FILTER_MASK_RST = 8'h00;
	localparam logic [5:0] STAT_HI_RST     = 6'h03;
	localparam logic [3:0] IE_RST          = 4'h0;

endpackage

// ### verilog/rx_store_mem.sv
/*
 * Byte store holding the two receive buffers.
 * Assumes one writer and one reader on the same clock; read data is
 * registered, so it is valid one cycle after the address.
 */
`timescale 1ns/1ps
module rx_store_mem #(
	parameter int ADDR_W = 5
) (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [7:0]        wdata,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [7:0]        rdata
);

	logic [7:0] mem_q [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem_q[raddr];
	end

endmodule

// ### verilog/can_irq_filter.sv
/*
 * CAN event flags, acceptance filter and double receive buffer with an
 * APB register slave.
 * Assumes the protocol engine inputs run on pclk (no synchronisers) and
 * that APB follows the usual setup/access sequence.
 */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module can_irq_filter
	import can_filter_pkg::*;
#(
	parameter int RX_BUF_BYTES = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        msg_start,
	input  wire logic [7:0]  frame_tag_bits,
	input  wire logic        msg_self_tx,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        msg_done,
	input  wire logic        msg_abort,
	input  wire logic        bus_off_in,
	input  wire logic        error_warning_in,
	input  wire logic        tx_active_in,
	input  wire logic        rx_active_in,
	input  wire logic        tx_done_in,
	input  wire logic        tx_buffer_free_in,
	input  wire logic        bus_wake,
	input  wire logic        ext_reset_req,
	output logic             can_cpu_interrupt,
	output logic             reset_request,
	output logic             test_mode_ctl,
	output logic             reference_output_enable,
	output logic             input0_select,
	output logic             input1_select,
	output logic             sleep_cmd,
	output logic             abort_tx_cmd,
	output logic             tx_request_cmd
);

	localparam int IDX_W = $clog2(RX_BUF_BYTES);

	logic [5:0]        reg_idx;
	logic              setup_ph;
	logic              access_ph;
	logic              done_ph;
	logic              wr_ctl;
	logic              wr_cmd;
	logic              wr_filt;
	logic              in_window;
	logic              mapped;
	logic [7:0]        rd_val;
	logic [5:0]        win_off;

	logic              ext_q;
	logic [3:0]        ie_q;
	logic [7:0]        filter_code_q;
	logic [7:0]        filter_mask_q;
	logic [5:0]        stat_q;
	logic [5:0]        stat_d;
	logic              dov_q;
	logic              rbs_q;
	logic [FLAG_W-1:0] flags_q;
	logic [FLAG_W-1:0] flags_d;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;

	logic              accept;
	logic              acc_full;
	logic              commit;
	logic              release_ev;
	logic              clr_ovr;
	logic              wake_ev;
	logic              storing_q;
	logic              self_q;
	logic [IDX_W:0]    idx_q;
	logic [1:0]        cnt_q;
	logic              wr_buf_q;
	logic              rd_buf_q;
	logic              mem_we;
	logic [IDX_W:0]    mem_raddr;
	logic [7:0]        mem_rdata;

	// APB decode; one wait state gives the buffer memory time to answer
	assign reg_idx   = paddr[7:2];
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable & ~pready;
	assign done_ph   = psel & penable & pready;
	assign win_off   = reg_idx - IDX_RX_WINDOW;
	assign in_window = (reg_idx >= IDX_RX_WINDOW) && (win_off < 6'(RX_BUF_BYTES));
	assign mapped    = (reg_idx <= IDX_FILTER_MASK) | in_window;
	assign wr_ctl    = done_ph & pwrite & (reg_idx == IDX_CONTROL);
	assign wr_cmd    = done_ph & pwrite & (reg_idx == IDX_COMMAND) & ~reset_request;
	assign wr_filt   = done_ph & pwrite & reset_request;

	always_comb begin
		rd_val = 8'h00;
		unique case (reg_idx)
			IDX_CONTROL: begin
				rd_val = {test_mode_ctl, 1'b0, reference_output_enable, ie_q, reset_request};
			end
			IDX_COMMAND: begin
				// Clear-overrun and release read high while reset is requested
				rd_val = {input0_select, input1_select, 1'b0, sleep_cmd,
					reset_request, reset_request, abort_tx_cmd, tx_request_cmd};
			end
			IDX_STATUS: begin
				rd_val = {stat_q, dov_q, rbs_q};
			end
			IDX_EVENT_FLAGS: begin
				rd_val = {3'b000, flags_q};
			end
			IDX_FILTER_CODE: begin
				rd_val = reset_request ? filter_code_q : 8'h00;
			end
			IDX_FILTER_MASK: begin
				rd_val = reset_request ? filter_mask_q : 8'h00;
			end
			default: begin
				rd_val = in_window ? mem_rdata : 8'h00;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access_ph;
			pslverr <= access_ph & ~mapped;
			if (access_ph) begin
				prdata <= {24'h00_0000, rd_val};
			end
		end
	end

	// Reset request: software, external reset or entering bus-off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_request <= 1'b1;
			ext_q         <= 1'b1;
		end else if (ext_reset_req) begin
			reset_request <= 1'b1;
			ext_q         <= 1'b1;
		end else if (bus_off_in & ~stat_q[ST_BUS_OFF - 2]) begin
			reset_request <= 1'b1;
		end else if (wr_ctl) begin
			reset_request <= pwdata[CTL_RESET_REQ];
			if (!pwdata[CTL_RESET_REQ]) begin
				ext_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_mode_ctl <= 1'b0;
			ie_q          <= IE_RST;
		end else begin
			if (reset_request) begin
				test_mode_ctl <= 1'b0;
			end else if (wr_ctl) begin
				test_mode_ctl <= pwdata[CTL_TEST_MODE];
			end
			if (wr_ctl) begin
				ie_q <= pwdata[CTL_OVR_IE:CTL_RX_IE];
			end
		end
	end

	// Pin-facing defaults follow only an externally caused reset request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_output_enable <= 1'b1;
			input0_select           <= 1'b1;
			input1_select           <= 1'b1;
		end else if (reset_request & ext_q) begin
			reference_output_enable <= 1'b1;
			input0_select           <= 1'b1;
			input1_select           <= 1'b1;
		end else begin
			if (wr_ctl) begin
				reference_output_enable <= pwdata[CTL_REF_OE];
			end
			if (wr_cmd) begin
				input0_select <= pwdata[CMD_IN0_SEL];
				input1_select <= pwdata[CMD_IN1_SEL];
			end
		end
	end

	// Commands; abort and transmit request are one-cycle strobes
	assign wake_ev    = sleep_cmd & (reset_request | bus_wake | (wr_cmd & ~pwdata[CMD_SLEEP]));
	assign clr_ovr    = reset_request | (wr_cmd & pwdata[CMD_CLR_OVR]);
	assign release_ev = reset_request | (wr_cmd & pwdata[CMD_RELEASE]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_cmd      <= 1'b0;
			abort_tx_cmd   <= 1'b0;
			tx_request_cmd <= 1'b0;
		end else begin
			if (reset_request | bus_wake) begin
				sleep_cmd <= 1'b0;
			end else if (wr_cmd) begin
				sleep_cmd <= pwdata[CMD_SLEEP];
			end
			abort_tx_cmd   <= wr_cmd & pwdata[CMD_ABORT];
			tx_request_cmd <= wr_cmd & pwdata[CMD_TX_REQ];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_code_q <= FILTER_CODE_RST;
			filter_mask_q <= FILTER_MASK_RST;
		end else if (wr_filt) begin
			if (reg_idx == IDX_FILTER_CODE) begin
				filter_code_q <= pwdata[7:0];
			end
			if (reg_idx == IDX_FILTER_MASK) begin
				filter_mask_q <= pwdata[7:0];
			end
		end
	end

	// Status bits 7..2 as shown to software
	always_comb begin
		stat_d                 = '0;
		stat_d[ST_BUS_OFF - 2] = (reset_request & ext_q) ? 1'b0 : bus_off_in;
		stat_d[ST_WARNING - 2] = (reset_request & ext_q) ? 1'b0 : error_warning_in;
		stat_d[ST_TX_BUSY - 2] = reset_request ? 1'b0 : tx_active_in;
		stat_d[ST_RX_BUSY - 2] = reset_request ? 1'b0 : rx_active_in;
		stat_d[ST_TX_DONE - 2] = reset_request ? 1'b1 : tx_done_in;
		stat_d[ST_TX_FREE - 2] = reset_request ? 1'b1 : tx_buffer_free_in;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= STAT_HI_RST;
		end else begin
			stat_q <= stat_d;
		end
	end

	// Filter: mask one makes a position don't-care
	assign accept   = msg_start & ~reset_request &
		(((frame_tag_bits ^ filter_code_q) & ~filter_mask_q) == 8'h00);
	assign acc_full = accept & (cnt_q == 2'd2);
	// Own transmissions are dropped at the end; the slot is reused
	assign commit   = storing_q & msg_done & ~self_q & ~reset_request;
	// Top index bit marks a full buffer, so bytes past the end never wrap
	assign mem_we   = storing_q & rx_byte_valid & ~idx_q[IDX_W];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			storing_q <= 1'b0;
			self_q    <= 1'b0;
			idx_q     <= '0;
		end else if (msg_done | msg_abort | reset_request) begin
			storing_q <= 1'b0;
		end else if (accept & ~acc_full) begin
			storing_q <= 1'b1;
			self_q    <= msg_self_tx;
			idx_q     <= '0;
		end else if (mem_we) begin
			// Excess bytes past the buffer end are discarded
			idx_q <= idx_q + {{IDX_W{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= 2'd0;
			wr_buf_q <= 1'b0;
			rd_buf_q <= 1'b0;
		end else if (reset_request) begin
			cnt_q    <= 2'd0;
			wr_buf_q <= 1'b0;
			rd_buf_q <= 1'b0;
		end else begin
			if (commit) begin
				wr_buf_q <= ~wr_buf_q;
			end
			if (release_ev & (cnt_q != 2'd0)) begin
				rd_buf_q <= ~rd_buf_q;
			end
			cnt_q <= cnt_q + {1'b0, commit} - {1'b0, release_ev & (cnt_q != 2'd0)};
		end
	end

	// Set wins over clear for both status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dov_q <= 1'b0;
			rbs_q <= 1'b0;
		end else begin
			if (acc_full) begin
				dov_q <= 1'b1;
			end else if (clr_ovr) begin
				dov_q <= 1'b0;
			end
			if (commit) begin
				rbs_q <= 1'b1;
			end else if (release_ev) begin
				rbs_q <= 1'b0;
			end
		end
	end

	// Event flags
	always_comb begin
		flag_set              = '0;
		flag_set[FLG_WAKE]    = wake_ev;
		flag_set[FLG_OVERRUN] = acc_full & ie_q[CTL_OVR_IE - 1];
		flag_set[FLG_ERROR]   = ie_q[CTL_ERR_IE - 1] &
			(stat_d[ST_BUS_OFF - 2:ST_WARNING - 2] != stat_q[ST_BUS_OFF - 2:ST_WARNING - 2]);
		flag_set[FLG_TX]      = ie_q[CTL_TX_IE - 1] & ~reset_request &
			stat_d[ST_TX_FREE - 2] & ~stat_q[ST_TX_FREE - 2];
		flag_set[FLG_RX]      = commit & ie_q[CTL_RX_IE - 1];
		// Only bits actually returned to the CPU are cleared
		flag_clr = '0;
		if (done_ph & ~pwrite & (reg_idx == IDX_EVENT_FLAGS)) begin
			flag_clr = prdata[FLAG_W-1:0];
		end
		if (reset_request) begin
			flag_clr[FLG_OVERRUN] = 1'b1;
			flag_clr[FLG_TX]      = 1'b1;
			flag_clr[FLG_RX]      = 1'b1;
		end
		flags_d = (flags_q & ~flag_clr) | flag_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q           <= '0;
			can_cpu_interrupt <= 1'b0;
		end else begin
			flags_q           <= flags_d;
			can_cpu_interrupt <= |flags_d;
		end
	end

	// CPU read of the buffer window; address issued in the setup cycle
	assign mem_raddr = {rd_buf_q, win_off[IDX_W-1:0]};

	rx_store_mem #(
		.ADDR_W(IDX_W + 1)
	) u_store (
		.clk  (pclk),
		.we   (mem_we),
		.waddr({wr_buf_q, idx_q[IDX_W-1:0]}),
		.wdata(rx_byte),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

endmodule

// ### verif/can_irq_filter_monitor.sv
/* Checker of the CAN event flag block, seeing only its ports.
   Assumes APB with one wait state and registered outputs. */
`timescale 1ns/1ps
module can_irq_filter_monitor #(
	parameter int RX_BUF_BYTES = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        ext_reset_req,
	input wire logic        can_cpu_interrupt,
	input wire logic        reset_request,
	input wire logic        test_mode_ctl,
	input wire logic        reference_output_enable,
	input wire logic        input0_select,
	input wire logic        input1_select,
	input wire logic        sleep_cmd,
	input wire logic        abort_tx_cmd,
	input wire logic        tx_request_cmd
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic flag_rd;
	// Completing read of the flag register, the only cause of a read-clear
	assign flag_rd = pready && !pwrite && paddr == 8'h0c;
	wait_state_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
		else $error("pready not after one wait state");
	flag_resv_a: assert property (flag_rd |-> prdata[31:5] == 27'h0)
		else $error("reserved flag bits read nonzero");
	irq_level_a: assert property (flag_rd |-> (prdata[4:0] != 5'h0) == $past(can_cpu_interrupt))
		else $error("interrupt disagrees with flags");
	irq_fall_a: assert property ($fell(can_cpu_interrupt) |-> $past(flag_rd) || reset_request)
		else $error("interrupt fell without read");
	filt_lock_a: assert property (pready && !pwrite && (paddr == 8'h10 || paddr == 8'h14)
		&& !reset_request |-> prdata == 32'h0)
		else $error("filter readable outside reset request");
	tmode_clr_a: assert property ($rose(reset_request) |-> ##[0:1] !test_mode_ctl)
		else $error("test mode kept on reset request");
	cmd_clr_a: assert property (reset_request && $past(reset_request)
		|-> !sleep_cmd && !abort_tx_cmd && !tx_request_cmd)
		else $error("command active under reset request");
	ext_def_a: assert property (ext_reset_req
		|-> ##[1:2] (reference_output_enable && input0_select && input1_select))
		else $error("external reset defaults missing");
	cmd_pulse_a: assert property (pready && pwrite && paddr == 8'h04 && !reset_request
		|=> abort_tx_cmd == $past(pwdata[1]) && tx_request_cmd == $past(pwdata[0])
		##1 !abort_tx_cmd && !tx_request_cmd)
		else $error("command strobe not a single cycle");
	cover property (flag_rd && prdata[0]);
	cover property (flag_rd && prdata[3]);
	cover property ($rose(reset_request));
endmodule
bind can_irq_filter can_irq_filter_monitor #(.RX_BUF_BYTES(RX_BUF_BYTES)) i_mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .ext_reset_req,
	.can_cpu_interrupt, .reset_request, .test_mode_ctl, .reference_output_enable,
	.input0_select, .input1_select, .sleep_cmd, .abort_tx_cmd, .tx_request_cmd);

// ### verif/can_engine_model.sv
/* Protocol engine model: message link, wake pulse and status levels.
   Assumes each task is entered just after a rising pclk edge. */
`timescale 1ns/1ps
module can_engine_model (
	input  wire logic       pclk,
	output logic            msg_start,
	output logic [7:0]      frame_tag_bits,
	output logic            msg_self_tx,
	output logic            rx_byte_valid,
	output logic [7:0]      rx_byte,
	output logic            msg_done,
	output logic            msg_abort,
	output logic            bus_wake,
	output logic [5:0]      lvl
);
	initial begin
		{msg_start, msg_self_tx, rx_byte_valid, msg_done, bus_wake, msg_abort} = 6'h00;
		frame_tag_bits = 8'h00;
		rx_byte = 8'h00;
		lvl = 6'h03;
	end
	// Idle lines carry the inverse, so a stale value can never pass as fresh
	task automatic send(input logic [7:0] tag, input logic self, input logic ab,
		input int n, input logic [7:0] b0);
		@(posedge pclk);
		msg_start <= 1'b1;
		frame_tag_bits <= tag;
		msg_self_tx <= self;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			msg_start <= 1'b0;
			frame_tag_bits <= ~tag;
			rx_byte_valid <= 1'b1;
			rx_byte <= b0 + 8'(i);
		end
		@(posedge pclk);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		msg_done <= ~ab;
		msg_abort <= ab;
		@(posedge pclk);
		msg_done <= 1'b0;
		msg_abort <= 1'b0;
	endtask
	task automatic wake();
		@(posedge pclk);
		bus_wake <= 1'b1;
		@(posedge pclk);
		bus_wake <= 1'b0;
	endtask
	task automatic set_lvl(input logic [5:0] v);
		@(posedge pclk);
		lvl <= v;
	endtask
endmodule

// ### verif/tb_can_irq_filter.sv
/* Self-checking bench: APB master and a reference model of flags and filter.
   Assumes the monitor binds itself and the engine model drives the link. */
`timescale 1ns/1ps
module tb_can_irq_filter;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv, acc;
	logic [7:0]  paddr, frame_tag_bits, rx_byte, tag, b0, code, mask;
	logic [31:0] pwdata, prdata, rdv;
	logic        msg_start, msg_self_tx, rx_byte_valid, msg_done, bus_wake, ext_reset_req;
	logic        msg_abort;
	logic        can_cpu_interrupt, reset_request, test_mode_ctl, reference_output_enable;
	logic        input0_select, input1_select, sleep_cmd, abort_tx_cmd, tx_request_cmd;
	logic [5:0]  lvl;
	int          seed, mismatches, samples_checked;
	can_irq_filter #(.RX_BUF_BYTES(16)) i_can_irq_filter (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .msg_start, .frame_tag_bits, .msg_self_tx, .rx_byte_valid, .rx_byte,
		.msg_done, .msg_abort, .bus_off_in(lvl[5]), .error_warning_in(lvl[4]),
		.tx_active_in(lvl[3]), .rx_active_in(lvl[2]), .tx_done_in(lvl[1]),
		.tx_buffer_free_in(lvl[0]), .bus_wake, .ext_reset_req, .can_cpu_interrupt,
		.reset_request, .test_mode_ctl, .reference_output_enable, .input0_select,
		.input1_select, .sleep_cmd, .abort_tx_cmd, .tx_request_cmd);
	can_engine_model i_engine (.pclk, .msg_start, .frame_tag_bits, .msg_self_tx,
		.rx_byte_valid, .rx_byte, .msg_done, .msg_abort, .bus_wake, .lvl);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps each strobe change apart from the next setup
		@(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	function automatic logic pass(input logic [7:0] t);
		return ((t ~^ code) | mask) == 8'hff;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		end_sim();
	end
	initial begin
		seed = 58379;
		mismatches = 0;
		samples_checked = 0;
		code = 8'ha5;
		mask = 8'h0f;
		{psel, penable, pwrite, ext_reset_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 32'h0);
		apb(1'b1, 8'h10, {24'h0, code});
		apb(1'b1, 8'h14, {24'h0, mask});
		rd(8'h10, {24'h0, code});
		rd(8'h14, {24'h0, mask});
		apb(1'b0, 8'hfc, 32'h0);
		chk({31'h0, errv}, 32'h1);
		apb(1'b1, 8'h0c, 32'hff);
		rd(8'h0c, 32'h0);
		apb(1'b1, 8'h00, 32'h1e);
		apb(1'b1, 8'h10, 32'hff);
		rd(8'h10, 32'h0);
		$display("register test done");
		for (int i = 0; i < 6; i++) begin
			tag = 8'($random(seed));
			b0 = 8'($random(seed));
			if (i < 3 || i == 5) tag[7:4] = code[7:4];
			else if (i == 3) tag[7:4] = code[7:4] ^ 4'h1;
			i_engine.send(tag, i == 2, i == 5, 3, b0);
			acc = pass(tag) && i != 2 && i != 5;
			apb(1'b0, 8'h08, 32'h0);
			chk(rdv & 32'h1, {31'h0, acc});
			rd(8'h0c, {31'h0, acc});
			rd(8'h0c, 32'h0);
			if (acc) begin
				rd(8'h50, {24'h0, b0});
				apb(1'b1, 8'h04, 32'h04);
			end
		end
		// Third message is own traffic: it must still overrun the full pair
		for (int i = 0; i < 3; i++) i_engine.send({code[7:4], 4'h0}, i == 2, 1'b0, 2, 8'h11);
		rd(8'h0c, 32'h09);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdv & 32'h3, 32'h3);
		$display("overrun test done");
		apb(1'b1, 8'h04, 32'h10);
		@(posedge pclk);
		chk({31'h0, sleep_cmd}, 32'h1);
		i_engine.wake();
		rd(8'h0c, 32'h10);
		i_engine.set_lvl(6'h13);
		rd(8'h0c, 32'h04);
		i_engine.set_lvl(6'h12);
		i_engine.set_lvl(6'h13);
		rd(8'h0c, 32'h02);
		$display("event test done");
		apb(1'b1, 8'h00, 32'h9e);
		apb(1'b1, 8'h04, 32'h03);
		i_engine.send({code[7:4], 4'h0}, 1'b0, 1'b0, 1, 8'h22);
		i_engine.set_lvl(6'h12);
		i_engine.set_lvl(6'h03);
		b0 = 8'($random(seed));
		i_engine.set_lvl({2'b00, b0[2:0], 1'b1});
		apb(1'b0, 8'h08, 32'h0);
		chk(rdv & 32'h3c, {26'h0, b0[2:0], 1'b1, 2'b00});
		@(posedge pclk);
		chk({31'h0, test_mode_ctl}, 32'h1);
		apb(1'b1, 8'h00, 32'h81);
		rd(8'h0c, 32'h04);
		chk({31'h0, test_mode_ctl}, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rdv & 32'h3f, 32'h0c);
		rd(8'h10, {24'h0, code});
		ext_reset_req <= 1'b1;
		@(posedge pclk);
		ext_reset_req <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({29'h0, reference_output_enable, input0_select, input1_select}, 32'h7);
		apb(1'b1, 8'h00, 32'h1e);
		i_engine.set_lvl(lvl | 6'h20);
		rd(8'h0c, 32'h04);
		chk({31'h0, reset_request}, 32'h1);
		$display("reset request test done");
		end_sim();
	end
endmodule
